// ---- rtl/gfx_fmt_regs.svh ----
// constants of the graphics pixel input formatter
`ifndef GFX_FMT_REGS_SVH
`define GFX_FMT_REGS_SVH

// ----------------------------------------------------------------
// widths and buffering
// ----------------------------------------------------------------
`define PIX_BUS_W 12
`define PIX_WORD_W 24
`define PIX_FIFO_DEPTH 4

// ----------------------------------------------------------------
// code levels
// ----------------------------------------------------------------
`define BLACK_CODE 8'h10
`define WHITE_CODE 8'heb
`define CDIFF_ZERO 8'h80
`define ZERO_CODE 8'h00

// ----------------------------------------------------------------
// full swing lift factors, shift 8
// ----------------------------------------------------------------
`define FS_LUMA_K 8'hdc
`define FS_CHROMA_K 8'he1
`define FS_SHIFT 4'h8

// ----------------------------------------------------------------
// gains, unity at 0x80 with shift 7
// ----------------------------------------------------------------
`define GAIN_UNITY 8'h80
`define GAIN_SHIFT 4'h7
`define LUMA_PRESET_SETUP 8'h76
`define LUMA_PRESET_NOSETUP 8'h80

// ----------------------------------------------------------------
// colour difference to rgb coefficients, scaled by 1024
// ----------------------------------------------------------------
`define CSC_RV 12'h57c
`define CSC_GU 12'h159
`define CSC_GV 12'h2cb
`define CSC_BU 12'h6ee
`define CSC_SHIFT 4'ha

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define FAST_CELL_RST 1'b0

`endif

// ---- rtl/gfx_fmt_pkg.sv ----
// types of the graphics pixel input formatter
package gfx_fmt_pkg;
    typedef enum logic [2:0] {
        LINK_IDLE = 3'b001,
        LINK_WAIT = 3'b010,
        LINK_RUN = 3'b100
    } link_state_t;

    typedef enum logic {
        FMT_RGB24 = 1'b0,
        FMT_RGB15 = 1'b1
    } pix_format_t;
endpackage

// ---- rtl/gfx_pixel_formatter.sv ----
// graphics pixel input formatter with its clock crossing buffer
//
// Notes on behaviour
// [R01] accept studio levels: black 16, white 235, zero 128
// [R02] optional lift of full 0..255 range
// [R03] optional colour difference to rgb conversion
// [R04] composite chroma gains, luma preset per set-up
// [R05] main path luma and colour difference gains
// [R06] fast input cell bit enables full speed
// [R07] fast input cell bit cleared by reset
// [R08] slot and edge pick half order and edge
// [R09] format 0 maps twelve pins to 24 bits
// [R10] format 1 maps eight pins to 15 bits
// [R11] software clears fast cell bit before power-down
// [R12] two halves join into one pixel per clock
// [R13] controller holds each half stable at its edge
`timescale 1ns/1ps
`include "gfx_fmt_regs.svh"

module gfx_cdc_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4
) (
    // write side
    input wire logic i_wclk,
    input wire logic i_wrst,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [WIDTH-1:0] i_wdata,
    // read side
    input wire logic i_rclk,
    input wire logic i_rrst,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [WIDTH-1:0] o_rdata
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wbin_r, wgray_r, rq1_r, rq2_r;
    logic [AW:0] rbin_r, rgray_r, wq1_r, wq2_r;
    logic [AW:0] wbin_nxt, rbin_nxt;
    logic wr_fire, rd_fire;

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        to_gray = b ^ (b >> 1);
    endfunction

    assign wbin_nxt = wbin_r + {{AW{1'b0}}, 1'b1};
    assign rbin_nxt = rbin_r + {{AW{1'b0}}, 1'b1};
    assign o_wready = wgray_r != {~rq2_r[AW:AW-1], rq2_r[AW-2:0]};
    assign o_rvalid = rgray_r != wq2_r;
    assign wr_fire = i_wvalid && o_wready;
    assign rd_fire = o_rvalid && i_rready;
    assign o_rdata = mem[rbin_r[AW-1:0]];

    // ----------------------------------------------------------------
    // write domain
    // ----------------------------------------------------------------
    always_ff @(posedge i_wclk) begin
        if (wr_fire) begin
            mem[wbin_r[AW-1:0]] <= i_wdata;
        end
    end

    always_ff @(posedge i_wclk) begin
        if (i_wrst) begin
            wbin_r <= '0;
            wgray_r <= '0;
            rq1_r <= '0;
            rq2_r <= '0;
        end else begin
            rq1_r <= rgray_r;
            rq2_r <= rq1_r;
            if (wr_fire) begin
                wbin_r <= wbin_nxt;
                wgray_r <= to_gray(wbin_nxt);
            end
        end
    end

    // ----------------------------------------------------------------
    // read domain
    // ----------------------------------------------------------------
    always_ff @(posedge i_rclk) begin
        if (i_rrst) begin
            rbin_r <= '0;
            rgray_r <= '0;
            wq1_r <= '0;
            wq2_r <= '0;
        end else begin
            wq1_r <= wgray_r;
            wq2_r <= wq1_r;
            if (rd_fire) begin
                rbin_r <= rbin_nxt;
                rgray_r <= to_gray(rbin_nxt);
            end
        end
    end
endmodule

module gfx_pixel_formatter
    import gfx_fmt_pkg::*;
(
    // system clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // pixel link
    input wire logic i_pix_clk,
    input wire logic [`PIX_BUS_W-1:0] i_pix_data,
    // capture and format control
    input wire logic i_slot,
    input wire logic i_edge,
    input wire logic i_format,
    input wire logic i_fast_input_cell_enable,
    // level and gain control
    input wire logic i_ycc_input,
    input wire logic i_rgb_convert,
    input wire logic i_full_swing,
    input wire logic [7:0] i_luma_gain,
    input wire logic [7:0] i_chroma_diff_gain,
    input wire logic [7:0] i_cvbs_cb_gain,
    input wire logic [7:0] i_cvbs_cr_gain,
    input wire logic i_cvbs_setup,
    // pixel stream out
    input wire logic i_pix_ready,
    output logic o_pix_valid,
    output logic [7:0] o_main_r,
    output logic [7:0] o_main_g,
    output logic [7:0] o_main_b,
    output logic [7:0] o_cvbs_y,
    output logic [7:0] o_cvbs_cb,
    output logic [7:0] o_cvbs_cr,
    // status
    output logic o_fast_input_cell_enable,
    output logic o_overflow
);
    // ----------------------------------------------------------------
    // arithmetic helpers
    // ----------------------------------------------------------------
    function automatic logic signed [19:0] ext8(input logic [7:0] v);
        ext8 = $signed({12'h000, v});
    endfunction

    function automatic logic signed [19:0] ext12(input logic [11:0] v);
        ext12 = $signed({8'h00, v});
    endfunction

    function automatic logic [7:0] clamp8(input logic signed [19:0] x);
        if (x < 20'sd0) begin
            clamp8 = 8'h00;
        end else if (x > 20'sd255) begin
            clamp8 = 8'hff;
        end else begin
            clamp8 = x[7:0];
        end
    endfunction

    // (v - ctr) * k >>> sh + off, clamped to a byte
    function automatic logic [7:0] scale(input logic [7:0] v,
                                         input logic [7:0] k,
                                         input logic [7:0] ctr,
                                         input logic [3:0] sh,
                                         input logic [7:0] off);
        logic signed [19:0] p;
        p = (ext8(v) - ext8(ctr)) * ext8(k);
        p = p >>> sh;
        scale = clamp8(p + ext8(off));
    endfunction

    // ----------------------------------------------------------------
    // link domain: reset and control crossing
    // ----------------------------------------------------------------
    logic rst_meta_r, link_rst;
    logic [2:0] ctl_meta_r, ctl_s_r;

    always_ff @(posedge i_pix_clk) begin
        rst_meta_r <= i_srst;
        link_rst <= rst_meta_r;
        ctl_meta_r <= {i_format, i_edge, i_slot};
        ctl_s_r <= ctl_meta_r;
    end

    // ----------------------------------------------------------------
    // link domain: double edge capture
    // ----------------------------------------------------------------
    logic [`PIX_BUS_W-1:0] rise_r, fall_r, fall_hold_r;
    link_state_t link_state_r, link_state_nxt;

    always_ff @(negedge i_pix_clk) begin
        fall_r <= i_pix_data;
    end

    always_ff @(posedge i_pix_clk) begin
        rise_r <= i_pix_data;
        fall_hold_r <= fall_r;
    end

    wire slot_s = ctl_s_r[0];
    wire edge_s = ctl_s_r[1];
    wire fmt15_s = ctl_s_r[2] == FMT_RGB15;
    wire [`PIX_BUS_W-1:0] first_half = edge_s ? fall_hold_r : rise_r; // [R08]
    wire [`PIX_BUS_W-1:0] second_half = edge_s ? rise_r : fall_r; // [R08]
    wire [`PIX_BUS_W-1:0] half_a = slot_s ? second_half : first_half; // [R08]
    wire [`PIX_BUS_W-1:0] half_b = slot_s ? first_half : second_half; // [R08]
    wire [4:0] r5 = half_b[6:2]; // [R10]
    wire [4:0] g5 = {half_b[1:0], half_a[7:5]}; // [R10]
    wire [4:0] b5 = half_a[4:0]; // [R10]
    wire [23:0] word24 = {half_b, half_a}; // [R09]
    wire [23:0] word15 = {r5, r5[4:2], g5, g5[4:2], b5, b5[4:2]}; // [R10]
    wire [23:0] link_word = fmt15_s ? word15 : word24;
    wire link_run = link_state_r == LINK_RUN;
    wire fifo_wready;
    wire link_wr = link_run; // [R12]
    logic drop_r;

    always_comb begin
        unique case (link_state_r)
            LINK_IDLE: link_state_nxt = LINK_WAIT;
            LINK_WAIT: link_state_nxt = LINK_RUN;
            LINK_RUN: link_state_nxt = LINK_RUN;
            default: link_state_nxt = LINK_IDLE;
        endcase
    end

    always_ff @(posedge i_pix_clk) begin
        if (link_rst) begin
            link_state_r <= LINK_IDLE;
            drop_r <= 1'b0;
        end else begin
            link_state_r <= link_state_nxt;
            drop_r <= drop_r || (link_run && !fifo_wready);
        end
    end

    // ----------------------------------------------------------------
    // crossing buffer
    // ----------------------------------------------------------------
    wire fifo_rvalid;
    wire [23:0] fifo_rdata;
    wire rd_en = fifo_rvalid && (!o_pix_valid || i_pix_ready);

    gfx_cdc_fifo #(
        .WIDTH(`PIX_WORD_W),
        .DEPTH(`PIX_FIFO_DEPTH)
    ) u_fifo (
        .i_wclk(i_pix_clk),
        .i_wrst(link_rst),
        .i_wvalid(link_wr),
        .o_wready(fifo_wready),
        .i_wdata(link_word),
        .i_rclk(i_clk),
        .i_rrst(i_srst),
        .o_rvalid(fifo_rvalid),
        .i_rready(rd_en),
        .o_rdata(fifo_rdata)
    );

    // ----------------------------------------------------------------
    // levels, gains and conversion
    // ----------------------------------------------------------------
    wire [7:0] in_r = fifo_rdata[23:16];
    wire [7:0] in_g = fifo_rdata[15:8];
    wire [7:0] in_b = fifo_rdata[7:0];
    wire convert = i_ycc_input && i_rgb_convert;
    wire [7:0] fs_g = scale(in_g, `FS_LUMA_K, `ZERO_CODE, `FS_SHIFT,
                            `BLACK_CODE); // [R02]
    wire [7:0] fs_rl = scale(in_r, `FS_LUMA_K, `ZERO_CODE, `FS_SHIFT,
                             `BLACK_CODE);
    wire [7:0] fs_bl = scale(in_b, `FS_LUMA_K, `ZERO_CODE, `FS_SHIFT,
                             `BLACK_CODE);
    wire [7:0] fs_rc = scale(in_r, `FS_CHROMA_K, `CDIFF_ZERO, `FS_SHIFT,
                             `CDIFF_ZERO); // [R02]
    wire [7:0] fs_bc = scale(in_b, `FS_CHROMA_K, `CDIFF_ZERO, `FS_SHIFT,
                             `CDIFF_ZERO);
    // studio coded words pass the level stage untouched
    wire [7:0] lev_g = i_full_swing ? fs_g : in_g; // [R01]
    wire [7:0] lev_r = !i_full_swing ? in_r : (i_ycc_input ? fs_rc : fs_rl);
    wire [7:0] lev_b = !i_full_swing ? in_b : (i_ycc_input ? fs_bc : fs_bl);
    wire [7:0] gy_g = scale(lev_g, i_luma_gain, `ZERO_CODE, `GAIN_SHIFT,
                            `ZERO_CODE); // [R05]
    wire [7:0] gy_r = scale(lev_r, i_luma_gain, `ZERO_CODE, `GAIN_SHIFT,
                            `ZERO_CODE);
    wire [7:0] gy_b = scale(lev_b, i_luma_gain, `ZERO_CODE, `GAIN_SHIFT,
                            `ZERO_CODE);
    wire [7:0] gcd_r = scale(lev_r, i_chroma_diff_gain, `CDIFF_ZERO,
                             `GAIN_SHIFT, `CDIFF_ZERO); // [R05]
    wire [7:0] gcd_b = scale(lev_b, i_chroma_diff_gain, `CDIFF_ZERO,
                             `GAIN_SHIFT, `CDIFF_ZERO); // [R05]
    wire [7:0] main_r_g = i_ycc_input ? gcd_r : gy_r;
    wire [7:0] main_b_g = i_ycc_input ? gcd_b : gy_b;
    wire signed [19:0] cr_d = ext8(main_r_g) - ext8(`CDIFF_ZERO);
    wire signed [19:0] cb_d = ext8(main_b_g) - ext8(`CDIFF_ZERO);
    wire signed [19:0] rv = (ext12(`CSC_RV) * cr_d) >>> `CSC_SHIFT;
    wire signed [19:0] gu = (ext12(`CSC_GU) * cb_d) >>> `CSC_SHIFT;
    wire signed [19:0] gv = (ext12(`CSC_GV) * cr_d) >>> `CSC_SHIFT;
    wire signed [19:0] bu = (ext12(`CSC_BU) * cb_d) >>> `CSC_SHIFT;
    wire [7:0] csc_r = clamp8(ext8(gy_g) + rv); // [R03]
    wire [7:0] csc_g = clamp8(ext8(gy_g) - gu - gv); // [R03]
    wire [7:0] csc_b = clamp8(ext8(gy_g) + bu); // [R03]
    wire [7:0] main_r_nxt = convert ? csc_r : main_r_g;
    wire [7:0] main_g_nxt = convert ? csc_g : gy_g;
    wire [7:0] main_b_nxt = convert ? csc_b : main_b_g;
    wire [7:0] preset = i_cvbs_setup ? `LUMA_PRESET_SETUP
                                     : `LUMA_PRESET_NOSETUP; // [R04]
    wire [7:0] cvbs_y_nxt = scale(lev_g, preset, `ZERO_CODE, `GAIN_SHIFT,
                                  `ZERO_CODE); // [R04]
    wire [7:0] cvbs_cb_nxt = scale(lev_b, i_cvbs_cb_gain, `CDIFF_ZERO,
                                   `GAIN_SHIFT, `CDIFF_ZERO); // [R04]
    wire [7:0] cvbs_cr_nxt = scale(lev_r, i_cvbs_cr_gain, `CDIFF_ZERO,
                                   `GAIN_SHIFT, `CDIFF_ZERO); // [R04]
    wire pix_valid_nxt = rd_en || (o_pix_valid && !i_pix_ready);

    // ----------------------------------------------------------------
    // output registers and status
    // ----------------------------------------------------------------
    logic ovf_meta_r;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_pix_valid <= 1'b0;
            o_main_r <= 8'h00;
            o_main_g <= 8'h00;
            o_main_b <= 8'h00;
            o_cvbs_y <= 8'h00;
            o_cvbs_cb <= 8'h00;
            o_cvbs_cr <= 8'h00;
        end else begin
            o_pix_valid <= pix_valid_nxt; // [R12]
            if (rd_en) begin
                o_main_r <= main_r_nxt;
                o_main_g <= main_g_nxt;
                o_main_b <= main_b_nxt;
                o_cvbs_y <= cvbs_y_nxt;
                o_cvbs_cb <= cvbs_cb_nxt;
                o_cvbs_cr <= cvbs_cr_nxt;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_fast_input_cell_enable <= `FAST_CELL_RST; // [R07]
            ovf_meta_r <= 1'b0;
            o_overflow <= 1'b0;
        end else begin
            o_fast_input_cell_enable <= i_fast_input_cell_enable; // [R06]
            ovf_meta_r <= drop_r;
            o_overflow <= ovf_meta_r;
        end
    end

    // ----------------------------------------------------------------
    // checks, link domain
    // ----------------------------------------------------------------
    sequence s_reset_release;
        $fell(link_rst);
    endsequence

    sequence s_prime_steps;
        ##1 (link_state_r == LINK_WAIT) ##1 (link_state_r == LINK_RUN);
    endsequence

    a_link_prime: assert property (@(posedge i_pix_clk) // [R12]
        s_reset_release |-> s_prime_steps)
        else $error("link did not reach run two clocks after reset");

    a_link_write: assert property (@(posedge i_pix_clk) // [R12]
        disable iff (link_rst) link_run && link_wr
        |=> u_fifo.wbin_r != $past(u_fifo.wbin_r) || drop_r)
        else $error("pixel word neither buffered nor flagged as dropped");

    a_slot_swap: assert property (@(posedge i_pix_clk) // [R08]
        disable iff (link_rst) slot_s && !edge_s
        |-> half_a == fall_r && half_b == rise_r)
        else $error("slot swap does not exchange the halves");

    a_edge_order: assert property (@(posedge i_pix_clk) // [R08]
        disable iff (link_rst) !slot_s && edge_s
        |-> half_a == $past(fall_r) && half_b == rise_r)
        else $error("falling edge half is not taken first");

    a_fmt0_map: assert property (@(posedge i_pix_clk) // [R09]
        disable iff (link_rst) link_run && !fmt15_s
        |-> link_word[23:16] == half_b[11:4]
            && link_word[15:8] == {half_b[3:0], half_a[11:8]}
            && link_word[7:0] == half_a[7:0])
        else $error("format 0 pin mapping wrong");

    a_fmt1_map: assert property (@(posedge i_pix_clk) // [R10]
        disable iff (link_rst) link_run && fmt15_s
        |-> link_word[23:19] == half_b[6:2]
            && link_word[15:11] == {half_b[1:0], half_a[7:5]}
            && link_word[7:3] == half_a[4:0])
        else $error("format 1 pin mapping wrong");

    // ----------------------------------------------------------------
    // checks, system domain
    // ----------------------------------------------------------------
    sequence s_unity_gain;
        i_luma_gain == `GAIN_UNITY && i_chroma_diff_gain == `GAIN_UNITY;
    endsequence

    a_studio_pass: assert property (@(posedge i_clk) // [R01]
        disable iff (i_srst) rd_en && !i_full_swing && i_ycc_input
        && !i_rgb_convert ##0 s_unity_gain
        |=> o_main_g == $past(in_g) && o_main_r == $past(in_r))
        else $error("studio level word altered at unity gain");

    a_full_swing: assert property (@(posedge i_clk) // [R02]
        disable iff (i_srst) rd_en && i_full_swing && !i_ycc_input
        && in_g == 8'hff ##0 s_unity_gain
        |=> o_main_g == `WHITE_CODE)
        else $error("full swing peak not lifted to white");

    a_csc_neutral: assert property (@(posedge i_clk) // [R03]
        disable iff (i_srst) rd_en && convert && !i_full_swing
        && in_r == `CDIFF_ZERO && in_b == `CDIFF_ZERO ##0 s_unity_gain
        |=> o_main_r == $past(in_g) && o_main_g == $past(in_g)
            && o_main_b == $past(in_g))
        else $error("grey word not grey after conversion");

    a_cvbs_gain: assert property (@(posedge i_clk) // [R04]
        disable iff (i_srst) rd_en && !i_full_swing && i_cvbs_setup
        && in_g == 8'h80 && in_b == `CDIFF_ZERO
        |=> o_cvbs_y == `LUMA_PRESET_SETUP && o_cvbs_cb == `CDIFF_ZERO)
        else $error("composite luma preset not applied");

    a_main_gain: assert property (@(posedge i_clk) // [R05]
        disable iff (i_srst) rd_en && i_ycc_input && !convert
        && !i_full_swing && in_g == 8'h80 && in_b == 8'hc0
        |=> o_main_g == $past(i_luma_gain)
            && o_main_b == {1'b0, $past(i_chroma_diff_gain[7:1])} + 8'h80)
        else $error("main path gains not applied");

    a_fast_cell_set: assert property (@(posedge i_clk) // [R06]
        disable iff (i_srst) i_fast_input_cell_enable ##1 !i_srst
        |-> o_fast_input_cell_enable)
        else $error("fast input cell bit not set");

    a_fast_cell_reset: assert property (@(posedge i_clk) // [R07]
        i_srst |=> !o_fast_input_cell_enable)
        else $error("fast input cell bit not cleared by reset");

    a_out_hold: assert property (@(posedge i_clk) // [R12]
        disable iff (i_srst) o_pix_valid && !i_pix_ready
        |=> o_pix_valid && $stable(o_main_g) && $stable(o_cvbs_y))
        else $error("stalled pixel changed or dropped");
endmodule

// ---- verif/gfx_ctrl_model.sv ----
// graphics controller model driving double edge pixel words
`timescale 1ns/1ps
module gfx_ctrl_model (
    // pixel link
    output logic o_pix_clk,
    output logic [11:0] o_pix_data
);
    initial begin
        o_pix_clk = 1'b0;
        o_pix_data = 12'h000;
    end
    // ------------------------------------------------------------
    // frame of n clocks; the clock stands still outside frames
    // ------------------------------------------------------------
    task automatic burst(input logic [11:0] rise_v,
                         input logic [11:0] fall_v, input int n);
        for (int k = 0; k < n; k++) begin
            #20 o_pix_data = rise_v;
            #20 o_pix_clk = 1'b1;
            #20 o_pix_data = fall_v;
            #20 o_pix_clk = 1'b0;
        end
        #20 o_pix_data = ~fall_v;
    endtask
endmodule

// ---- verif/graphics_pixel_input_formatter_bench.sv ----
// self-checking bench of the graphics pixel input formatter
`timescale 1ns/1ps
`include "gfx_fmt_regs.svh"
module graphics_pixel_input_formatter_bench
    import gfx_fmt_pkg::*;
();
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic pix_clk;
    logic [11:0] pix_data;
    logic i_slot = 1'b0, i_edge = 1'b0, i_format = 1'b0, i_fast = 1'b0;
    logic i_ycc = 1'b0, i_conv = 1'b0, i_fs = 1'b0, i_setup = 1'b0;
    logic i_ready = 1'b1;
    logic [7:0] i_gy = 8'h80, i_gcd = 8'h80, i_gcb = 8'h80, i_gcr = 8'h80;
    logic o_valid, o_fast, o_ovf;
    logic [7:0] o_r, o_g, o_b, o_cy, o_ccb, o_ccr;
    logic [47:0] last = 48'h0;
    int failures = 0;
    int checked = 0;
    always #50 i_clk = ~i_clk;
    gfx_ctrl_model gc (.o_pix_clk(pix_clk), .o_pix_data(pix_data));
    gfx_pixel_formatter uut (.i_clk(i_clk), .i_srst(i_srst),
        .i_pix_clk(pix_clk), .i_pix_data(pix_data), .i_slot(i_slot),
        .i_edge(i_edge), .i_format(i_format),
        .i_fast_input_cell_enable(i_fast), .i_ycc_input(i_ycc),
        .i_rgb_convert(i_conv), .i_full_swing(i_fs), .i_luma_gain(i_gy),
        .i_chroma_diff_gain(i_gcd), .i_cvbs_cb_gain(i_gcb),
        .i_cvbs_cr_gain(i_gcr), .i_cvbs_setup(i_setup),
        .i_pix_ready(i_ready), .o_pix_valid(o_valid), .o_main_r(o_r),
        .o_main_g(o_g), .o_main_b(o_b), .o_cvbs_y(o_cy),
        .o_cvbs_cb(o_ccb), .o_cvbs_cr(o_ccr),
        .o_fast_input_cell_enable(o_fast), .o_overflow(o_ovf));
    // ------------------------------------------------------------
    // last pixel taken downstream
    // ------------------------------------------------------------
    always @(posedge i_clk) begin
        if (o_valid === 1'b1 && i_ready === 1'b1) begin
            last <= {o_r, o_g, o_b, o_cy, o_ccb, o_ccr};
        end
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic drain();
        int k;
        k = 0;
        repeat (8) @(negedge i_clk);
        while (o_valid !== 1'b0 && k < 60) begin
            @(negedge i_clk);
            k++;
        end
        if (k == 60) begin
            failures++;
            wrap_up();
        end
    endtask
    // halves a (green/blue) and b (red/green) ordered by slot and edge
    task automatic push(input logic [11:0] ha, input logic [11:0] hb);
        logic [11:0] first, second;
        first = i_slot ? hb : ha;
        second = i_slot ? ha : hb;
        if (i_edge) begin
            gc.burst(second, first, 8);
        end else begin
            gc.burst(first, second, 8);
        end
        drain();
    endtask
    task automatic do_reset();
        fork
            gc.burst(12'h000, 12'h000, 12);
            begin
                @(negedge i_clk);
                i_srst = 1'b1;
                repeat (8) @(negedge i_clk);
                check(o_fast, 48'h0);
                i_srst = 1'b0;
            end
        join
        @(negedge i_clk);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        do_reset();
        check({o_valid, o_fast, o_ovf, o_r}, 48'h0);
        i_fast = 1'b1;
        repeat (2) @(negedge i_clk);
        check(o_fast, 48'h1);
        do_reset();
        $display("test reset done");
    endtask
    task automatic t_fmt0();
        for (int s = 0; s < 4; s++) begin
            i_slot = s[0];
            i_edge = s[1];
            push(12'ha96, 12'hc53);
            check(last[47:24], 24'hc53a96);
        end
        $display("test format 0 done");
    endtask
    task automatic t_fmt1();
        i_format = 1'b1;
        i_slot = 1'b1;
        i_edge = 1'b0;
        push(12'hf7e, 12'hfd5);
        check(last[47:24], 24'had5af7);
        i_format = 1'b0;
        i_slot = 1'b0;
        $display("test format 1 done");
    endtask
    task automatic t_levels();
        i_fs = 1'b1;
        push(12'h0ff, 12'hff0);
        check(last[47:24], 24'heb10eb);
        push(12'hf00, 12'h00f);
        check(last[47:24], 24'h10eb10);
        i_fs = 1'b0;
        i_gy = 8'h40;
        push(12'h0c0, 12'h804);
        check(last[47:24], 24'h402060);
        i_ycc = 1'b1;
        i_gcd = 8'h40;
        i_gcb = 8'h40;
        push(12'h040, 12'hc0a);
        check(last, 48'ha05060a060c0);
        push(12'h0c0, 12'h808);
        check(last, 48'h8040a080a080);
        i_setup = 1'b1;
        push(12'h040, 12'hc0a);
        check(last[23:16], 8'h93);
        i_gy = 8'h80;
        i_gcd = 8'h80;
        push(12'h080, 12'h808);
        check(last, 48'h808080768080);
        i_conv = 1'b1;
        push(12'hb80, 12'h80e);
        check(last[47:24], 24'hebebeb);
        push(12'h080, 12'h801);
        check(last[47:24], 24'h101010);
        $display("test levels done");
    endtask
    task automatic t_ovf();
        do_reset();
        check({o_ovf, o_valid}, 48'h0);
        i_ready = 1'b0;
        gc.burst(12'h123, 12'h456, 10);
        repeat (8) @(negedge i_clk);
        check({o_ovf, o_valid}, 48'h3);
        i_ready = 1'b1;
        drain();
        check(o_ovf, 48'h1);
        i_fast = 1'b0;
        do_reset();
        check({o_ovf, o_fast}, 48'h0);
        $display("test overflow done");
    endtask
    initial begin
        t_reset();
        t_fmt0();
        t_fmt1();
        t_levels();
        t_ovf();
        wrap_up();
    end
endmodule
